// ==== design/ipc_cmd_top.sv ====
// Interactive peripheral command handler: cursors, serial output, receive buffers, status words
//
// What this block does
// - Cursor query returns X word, Y-plus-flags word
// - Shown flag reflects cursor currently visible
// - Track flag mirrors pointing device track switch
// - Write command sends one byte to port
// - Transmit completion raises enabled transmit request
// - Ports transmit independently, overlapping starts accepted
// - Port codes 0-3 board one, 4-7 board two; cursor codes 0-1 board one, 2-3 board two
// - Every byte value 00 to FF accepted
// - Eight ports, sixteen-byte receive buffer each
// - One enabled receive request per received byte
// - Reading port data clears its status bit
// - Reset empties every receive buffer
// - Read word: fault, overrun, empty, byte
// - Status query selects board by device field
// - Status word names interrupting or ready source
// - Cursor event on enter or tracked move
// - Cursor event held until cursor queried
// - Transmit bit low while sending, high after
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps

module ipc_cmd_top (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [3:0]       bus_addr,
	input  wire logic [31:0]      bus_wdata,
	input  wire logic             bus_wr,
	input  wire logic             bus_rd,
	output logic      [31:0]      bus_rdata,
	output logic      [7:0]       tx_valid,
	output logic      [7:0][7:0]  tx_char,
	input  wire logic [7:0]       tx_done,
	output logic      [7:0]       tx_irq,
	input  wire logic [7:0]       rx_toggle,
	input  wire logic [7:0][7:0]  rx_data,
	input  wire logic [7:0]       rx_hardware_fault_flag,
	output logic      [7:0]       rx_irq,
	input  wire logic [3:0][9:0]  cur_x,
	input  wire logic [3:0][9:0]  cur_y,
	input  wire logic [3:0]       cursor_shown_flag,
	input  wire logic [3:0]       cursor_flash_flag,
	input  wire logic             pd_enter,
	input  wire logic             tracking_on_flag,
	input  wire logic [1:0]       pd_select
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------

	// Every flip-flop of the block lives in this one record
	typedef struct packed {
		ipc_pkg::ipc_phase_t   phase;
		logic [2:0]            wait_dev;
		logic                  wait_ok;
		logic [7:0]            tx_busy;
		logic [7:0][7:0]       tx_data;
		logic [7:0]            txd1;
		logic [7:0]            txd2;
		logic [7:0]            txd3;
		logic [7:0]            rxt1;
		logic [7:0]            rxt2;
		logic [7:0]            rxt3;
		logic [7:0][7:0]       rxd1;
		logic [7:0][7:0]       rxd2;
		logic [7:0]            rxf1;
		logic [7:0]            rxf2;
		logic [3:0]            pd1;
		logic [3:0]            pd2;
		logic                  enter_prev;
		logic [3:0][9:0]       cx_prev;
		logic [3:0][9:0]       cy_prev;
		logic                  txie;
		logic                  rxie;
		logic [7:0][15:0][8:0] rbuf;
		logic [7:0][3:0]       wp;
		logic [7:0][3:0]       rp;
		logic [7:0][4:0]       cnt;
		logic [7:0]            ovf;
		logic [7:0]            rx_new;
		logic [3:0]            cev;
		logic [15:0]           res0;
		logic [15:0]           res1;
		logic [1:0]            res_cnt;
		logic [31:0]           rdata;
		logic [7:0]            tx_irq;
		logic [7:0]            rx_irq;
		logic [1:0]            warm;
	} ipc_state_t;

	ipc_state_t q;
	ipc_state_t d;

	// Working values of the combinational process
	logic [2:0]  pi;
	logic [15:0] w;
	logic [7:0]  cmd_op;
	logic [7:0]  cmd_dev;
	logic [7:0]  tx_fin_evt;
	logic [7:0]  rx_evt;
	logic [3:0]  cev_set;
	logic        cnt_over;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Status word of one link board: free outputs, new input, cursor events
	function automatic logic [15:0] ps_word(input ipc_state_t s, input logic b);
		logic [15:0] r;
		r = 16'h0000;
		r[ipc_pkg::PS_TX_LSB +: 4]  = ~s.tx_busy[{b, 2'b00} +: 4];
		r[ipc_pkg::PS_RX_LSB +: 4]  = s.rx_new[{b, 2'b00} +: 4];
		r[ipc_pkg::PS_CUR_LSB +: 2] = s.cev[{b, 1'b0} +: 2];
		return r;
	endfunction

	// Decoded events seen by the combinational process
	always_comb
	begin
		cmd_op     = bus_wdata[15:8];
		cmd_dev    = bus_wdata[7:0];
		tx_fin_evt = q.tx_busy & q.txd2 & ~q.txd3;
		// A toggle line left high across reset must not look like a fresh byte
		rx_evt     = (q.rxt2 ^ q.rxt3) & {8{&q.warm}};
		cnt_over   = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (q.cnt[i] > ipc_pkg::BUF_DEPTH)
			begin
				cnt_over = 1'b1;
			end
		end
		for (int m = 0; m < 4; m++)
		begin
			cev_set[m] = (&q.warm) && (q.pd2[1:0] == 2'(m)) &&
				((q.pd2[3] && !q.enter_prev) ||
				(q.pd2[2] && (cur_x[m] != q.cx_prev[m] || cur_y[m] != q.cy_prev[m])));
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	always_comb
	begin
		d  = q;
		pi = cmd_dev[2:0];
		w  = 16'h0000;

		// Pulses and read data last one cycle only
		d.tx_irq = 8'h00;
		d.rx_irq = 8'h00;
		d.rdata  = 32'h0000_0000;

		// Two-stage synchronisers for everything from the link boards
		d.txd1 = tx_done;
		d.txd2 = q.txd1;
		d.txd3 = q.txd2;
		d.rxt1 = rx_toggle;
		d.rxt2 = q.rxt1;
		d.rxt3 = q.rxt2;
		d.rxd1 = rx_data;
		d.rxd2 = q.rxd1;
		d.rxf1 = rx_hardware_fault_flag;
		d.rxf2 = q.rxf1;
		d.pd1  = {pd_enter, tracking_on_flag, pd_select};
		d.pd2  = q.pd1;
		d.enter_prev = q.pd2[3];
		d.cx_prev    = cur_x;
		d.cy_prev    = cur_y;

		// Receive and cursor edge detectors stay deaf until the synchronisers hold real pin levels
		d.warm = q.warm + {1'b0, ~&q.warm};

		// Command port writes; clears come first so that later sets win
		if (bus_wr && bus_addr == ipc_pkg::ADDR_CMD)
		begin
			d.phase = ipc_pkg::IPC_IDLE;
			case (cmd_op)
				ipc_pkg::OP_CURSOR_STATUS_QUERY:
				begin
					d.res0    = 16'h0000;
					d.res1    = 16'h0000;
					d.res_cnt = 2'h2;
					if (cmd_dev < ipc_pkg::NUM_CURSORS)
					begin
						d.res0[9:0] = cur_x[pi[1:0]];
						d.res1[9:0] = cur_y[pi[1:0]];
						d.res1[ipc_pkg::CUR_ENTER_BIT] = q.pd2[3];
						d.res1[ipc_pkg::CUR_TRACK_BIT] = q.pd2[2];
						d.res1[ipc_pkg::CUR_FLASH_BIT] = cursor_flash_flag[pi[1:0]];
						d.res1[ipc_pkg::CUR_SHOWN_BIT] = cursor_shown_flag[pi[1:0]];
						d.cev[pi[1:0]] = 1'b0;
					end
				end
				ipc_pkg::OP_SERIAL_CHAR_WRITE:
				begin
					d.phase    = ipc_pkg::IPC_WAIT_CHAR;
					d.wait_dev = pi;
					d.wait_ok  = cmd_dev < ipc_pkg::NUM_PORTS;
				end
				ipc_pkg::OP_SERIAL_CHAR_READ:
				begin
					if (cmd_dev < ipc_pkg::NUM_PORTS)
					begin
						if (q.cnt[pi] == 5'h00)
						begin
							w[ipc_pkg::RX_EMPTY_BIT] = 1'b1;
						end
						else
						begin
							w[7:0] = q.rbuf[pi][q.rp[pi]][7:0];
							w[ipc_pkg::RX_FAULT_BIT] = q.rbuf[pi][q.rp[pi]][8];
							d.rp[pi]  = q.rp[pi] + 4'h1;
							d.cnt[pi] = q.cnt[pi] - 5'h01;
						end
						w[ipc_pkg::RX_OVERRUN_BIT] = q.ovf[pi];
						d.ovf[pi]    = 1'b0;
						d.rx_new[pi] = 1'b0;
					end
					else
					begin
						w[ipc_pkg::RX_EMPTY_BIT] = 1'b1;
					end
					d.res0    = w;
					d.res_cnt = 2'h1;
				end
				ipc_pkg::OP_PERIPHERAL_STATUS_QUERY:
				begin
					d.res0    = (cmd_dev < ipc_pkg::NUM_BOARDS) ? ps_word(q, pi[0]) : 16'h0000;
					d.res_cnt = 2'h1;
				end
				default:
				begin
					d.res_cnt = q.res_cnt;
				end
			endcase
		end

		// Character word that follows a write command
		if (bus_wr && bus_addr == ipc_pkg::ADDR_DATA)
		begin
			case (q.phase)
				ipc_pkg::IPC_WAIT_CHAR:
				begin
					d.phase = ipc_pkg::IPC_IDLE;
					if (q.wait_ok)
					begin
						d.tx_busy[q.wait_dev] = 1'b1;
						d.tx_data[q.wait_dev] = bus_wdata[7:0];
					end
				end
				default:
				begin
					d.phase = ipc_pkg::IPC_IDLE;
				end
			endcase
		end

		// Interrupt enables
		if (bus_wr && bus_addr == ipc_pkg::ADDR_CTRL)
		begin
			d.txie = bus_wdata[ipc_pkg::CTRL_TXIE_BIT];
			d.rxie = bus_wdata[ipc_pkg::CTRL_RXIE_BIT];
		end

		// Register reads; a result word is consumed by its read
		if (bus_rd)
		begin
			case (bus_addr)
				ipc_pkg::ADDR_DATA:
				begin
					if (q.res_cnt != 2'h0)
					begin
						d.rdata[15:0] = q.res0;
						d.res0    = q.res1;
						d.res_cnt = q.res_cnt - 2'h1;
					end
				end
				ipc_pkg::ADDR_CTRL:
				begin
					d.rdata[ipc_pkg::CTRL_TXIE_BIT] = q.txie;
					d.rdata[ipc_pkg::CTRL_RXIE_BIT] = q.rxie;
				end
				ipc_pkg::ADDR_STAT:
				begin
					d.rdata[7:0] = q.tx_busy;
					for (int i = 0; i < 8; i++)
					begin
						d.rdata[ipc_pkg::STAT_RXNE_LSB + i] = q.cnt[i] != 5'h00;
					end
					d.rdata[ipc_pkg::STAT_RESCNT_LSB +: 2] = q.res_cnt;
					d.rdata[ipc_pkg::STAT_WAIT_BIT] = q.phase == ipc_pkg::IPC_WAIT_CHAR;
				end
				default:
				begin
					d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Transmit completion on the rising edge of a port's done level
		for (int i = 0; i < 8; i++)
		begin
			if (tx_fin_evt[i])
			begin
				d.tx_busy[i] = 1'b0;
				d.tx_irq[i]  = q.txie;
			end
		end

		// Received bytes go into their port's buffer; a full buffer overruns
		for (int i = 0; i < 8; i++)
		begin
			if (rx_evt[i])
			begin
				if (d.cnt[i] == ipc_pkg::BUF_DEPTH)
				begin
					d.ovf[i] = 1'b1;
				end
				else
				begin
					d.rbuf[i][d.wp[i]] = {q.rxf2[i], q.rxd2[i]};
					d.wp[i]  = d.wp[i] + 4'h1;
					d.cnt[i] = d.cnt[i] + 5'h01;
				end
				d.rx_new[i] = 1'b1;
				d.rx_irq[i] = q.rxie;
			end
		end

		// Cursor events; a new event beats the clear of a query
		for (int m = 0; m < 4; m++)
		begin
			if (cev_set[m])
			begin
				d.cev[m] = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// Reset empties every buffer and drops any pending exchange
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			q      <= '0;
			q.txie <= ipc_pkg::CTRL_RESET[ipc_pkg::CTRL_TXIE_BIT];
			q.rxie <= ipc_pkg::CTRL_RESET[ipc_pkg::CTRL_RXIE_BIT];
		end
		else
		begin
			q <= d;
		end
	end

	// Outputs straight from the state record
	assign bus_rdata = q.rdata;
	assign tx_valid  = q.tx_busy;
	assign tx_char   = q.tx_data;
	assign tx_irq    = q.tx_irq;
	assign rx_irq    = q.rx_irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	property p_cursor_words;
		@(posedge mclk) disable iff (rst)
		(bus_wr && bus_addr == ipc_pkg::ADDR_CMD && cmd_op == ipc_pkg::OP_CURSOR_STATUS_QUERY)
		|=> (q.res_cnt == 2'h2 && q.res0[15:10] == 6'h00 && q.res1[15:14] == 2'h0);
	endproperty
	a_cursor_words: assert property (p_cursor_words) else $error("cursor query did not load two words");

	property p_send_char;
		@(posedge mclk) disable iff (rst)
		(bus_wr && bus_addr == ipc_pkg::ADDR_DATA && q.phase == ipc_pkg::IPC_WAIT_CHAR && q.wait_ok)
		|=> (tx_valid[q.wait_dev] && tx_char[q.wait_dev] == $past(bus_wdata[7:0]));
	endproperty
	a_send_char: assert property (p_send_char) else $error("character not started on selected port");

	property p_tx_done;
		@(posedge mclk) disable iff (rst)
		(tx_fin_evt != 8'h00) |=> ((tx_valid & $past(tx_fin_evt)) == 8'h00);
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("port still busy after completion");

	property p_tx_irq;
		@(posedge mclk) disable iff (rst)
		(q.txie && tx_fin_evt != 8'h00) |=> (tx_irq == $past(tx_fin_evt));
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit request missing");

	property p_rx_irq;
		@(posedge mclk) disable iff (rst)
		(q.rxie && rx_evt != 8'h00) |=> (rx_irq == $past(rx_evt));
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("receive request not one per byte");

	property p_buf_bound;
		@(posedge mclk) disable iff (rst)
		!cnt_over;
	endproperty
	a_buf_bound: assert property (p_buf_bound) else $error("receive buffer above sixteen bytes");

	property p_reset_empty;
		@(posedge mclk) disable iff (rst)
		$fell(rst) |-> (q.cnt == '0 && q.ovf == 8'h00 && q.res_cnt == 2'h0);
	endproperty
	a_reset_empty: assert property (p_reset_empty) else $error("buffers not empty after reset");

	property p_reset_quiet;
		@(posedge mclk) disable iff (rst)
		$fell(rst) |-> ##3 (q.cnt == '0 && rx_irq == 8'h00);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("byte taken from before reset");

	property p_read_clears;
		@(posedge mclk) disable iff (rst)
		(bus_wr && bus_addr == ipc_pkg::ADDR_CMD && cmd_op == ipc_pkg::OP_SERIAL_CHAR_READ
			&& cmd_dev < ipc_pkg::NUM_PORTS && !rx_evt[cmd_dev[2:0]])
		|=> !q.rx_new[$past(bus_wdata[2:0])];
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("status bit survived data read");

	property p_empty_flag;
		@(posedge mclk) disable iff (rst)
		(bus_wr && bus_addr == ipc_pkg::ADDR_CMD && cmd_op == ipc_pkg::OP_SERIAL_CHAR_READ
			&& cmd_dev < ipc_pkg::NUM_PORTS && q.cnt[cmd_dev[2:0]] == 5'h00)
		|=> (q.res0[ipc_pkg::RX_EMPTY_BIT] && q.res0[7:0] == 8'h00 && q.res_cnt == 2'h1);
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty buffer not flagged");

	property p_cev_clear;
		@(posedge mclk) disable iff (rst)
		(bus_wr && bus_addr == ipc_pkg::ADDR_CMD && cmd_op == ipc_pkg::OP_CURSOR_STATUS_QUERY
			&& cmd_dev < ipc_pkg::NUM_CURSORS && !cev_set[cmd_dev[1:0]])
		|=> !q.cev[$past(bus_wdata[1:0])];
	endproperty
	a_cev_clear: assert property (p_cev_clear) else $error("cursor event not cleared by query");

	property p_data_read;
		@(posedge mclk) disable iff (rst)
		(bus_rd && bus_addr == ipc_pkg::ADDR_DATA && q.res_cnt != 2'h0)
		|=> (bus_rdata[15:0] == $past(q.res0) && bus_rdata[31:16] == 16'h0000) ##1 (bus_rdata == 32'h0 || $past(bus_rd));
	endproperty
	a_data_read: assert property (p_data_read) else $error("result word not returned");

endmodule

// ==== design/ipc_pkg.sv ====
// Constants and types shared by the interactive peripheral command handler
package ipc_pkg;

	// ------------------------------------------------------------------
	// Register offsets on the plain register port (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_CMD  = 4'h0;
	localparam logic [3:0] ADDR_DATA = 4'h4;
	localparam logic [3:0] ADDR_CTRL = 4'h8;
	localparam logic [3:0] ADDR_STAT = 4'hC;

	// ------------------------------------------------------------------
	// Command opcodes, carried in bits 15:8 of a command word
	// ------------------------------------------------------------------
	localparam logic [7:0] OP_CURSOR_STATUS_QUERY     = 8'h17;
	localparam logic [7:0] OP_SERIAL_CHAR_WRITE       = 8'h18;
	localparam logic [7:0] OP_SERIAL_CHAR_READ        = 8'h19;
	localparam logic [7:0] OP_PERIPHERAL_STATUS_QUERY = 8'h1A;

	// ------------------------------------------------------------------
	// Configuration limits: unit counts checked against the device field, BUF_DEPTH against buffer fill
	// ------------------------------------------------------------------
	localparam logic [7:0] NUM_PORTS   = 8'h08;
	localparam logic [7:0] NUM_CURSORS = 8'h04;
	localparam logic [7:0] NUM_BOARDS  = 8'h02;
	localparam logic [4:0] BUF_DEPTH   = 5'h10;

	// ------------------------------------------------------------------
	// Field positions of the result words and of the control and status registers
	// ------------------------------------------------------------------
	localparam int CUR_ENTER_BIT   = 13;
	localparam int CUR_TRACK_BIT   = 12;
	localparam int CUR_FLASH_BIT   = 11;
	localparam int CUR_SHOWN_BIT   = 10;
	localparam int RX_FAULT_BIT    = 15;
	localparam int RX_OVERRUN_BIT  = 14;
	localparam int RX_EMPTY_BIT    = 13;
	localparam int PS_TX_LSB       = 0;
	localparam int PS_RX_LSB       = 4;
	localparam int PS_CUR_LSB      = 8;
	localparam int CTRL_TXIE_BIT   = 0;
	localparam int CTRL_RXIE_BIT   = 1;
	localparam int STAT_RXNE_LSB   = 8;
	localparam int STAT_RESCNT_LSB = 16;
	localparam int STAT_WAIT_BIT   = 18;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// Command phase: idle, or holding a write command for its character word
	typedef enum logic {
		IPC_IDLE,
		IPC_WAIT_CHAR
	} ipc_phase_t;

endpackage

// ==== test/ipc_link_model.sv ====
// Link board model: transmit completion and receive byte source
`timescale 1ns/100ps

module ipc_link_model (
	input  wire logic            mclk,
	input  wire logic            rst,
	input  wire logic [7:0]      tx_valid,
	output logic      [7:0]      tx_done,
	output logic      [7:0]      rx_toggle,
	output logic      [7:0][7:0] rx_data,
	output logic      [7:0]      rx_hardware_fault_flag
);
	int cnt [8];

	// Lines start idle
	initial
	begin
		tx_done = 8'h00;
		rx_toggle = 8'h00;
		rx_data = '0;
		rx_hardware_fault_flag = 8'h00;
	end

	// Each port finishes after its own delay; done drops once the port is idle again
	always @(posedge mclk)
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (rst || !tx_valid[i])
			begin
				cnt[i] = 0;
				tx_done[i] <= 1'b0;
			end
			else if (cnt[i] == 10 + 4 * i)
				tx_done[i] <= 1'b1;
			else
				cnt[i] = cnt[i] + 1;
		end
	end

	// One byte per toggle; data and fault lines are inverted once the hold time has run out
	task automatic send(input int p, input logic [7:0] b, input logic f);
		@(posedge mclk);
		rx_data[p] <= b;
		rx_hardware_fault_flag[p] <= f;
		rx_toggle[p] <= ~rx_toggle[p];
		repeat (6) @(posedge mclk);
		rx_data[p] <= ~b;
		rx_hardware_fault_flag[p] <= ~f;
	endtask
endmodule

// ==== test/test_interactive_peripheral_commands.sv ====
// Self-checking bench for the interactive peripheral command handler
`timescale 1ns/100ps

module test_interactive_peripheral_commands;
	logic            mclk;
	logic            rst = 1'b1;
	logic [3:0]      bus_addr = 4'h0;
	logic [31:0]     bus_wdata = 32'h0;
	logic            bus_wr = 1'b0;
	logic            bus_rd = 1'b0;
	logic [31:0]     bus_rdata;
	logic [7:0]      tx_valid;
	logic [7:0][7:0] tx_char;
	logic [7:0]      tx_done;
	logic [7:0]      tx_irq;
	logic [7:0]      rx_toggle;
	logic [7:0][7:0] rx_data;
	logic [7:0]      rx_hardware_fault_flag;
	logic [7:0]      rx_irq;
	logic [3:0][9:0] cur_x = '0;
	logic [3:0][9:0] cur_y = '0;
	logic [3:0]      cursor_shown_flag = 4'h0;
	logic [3:0]      cursor_flash_flag = 4'h0;
	logic            pd_enter = 1'b0;
	logic            tracking_on_flag = 1'b0;
	logic [1:0]      pd_select = 2'h0;
	int              n_errors = 0;
	int              cmp_count = 0;
	int              cycles = 0;
	int              tx_irqs [8] = '{default: 0};
	int              rx_irqs [8] = '{default: 0};
	logic [31:0]     w;
	logic [7:0]      ch;

	ipc_cmd_top DUT (
		.mclk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.tx_valid, .tx_char, .tx_done, .tx_irq, .rx_toggle, .rx_data, .rx_hardware_fault_flag, .rx_irq,
		.cur_x, .cur_y, .cursor_shown_flag, .cursor_flash_flag, .pd_enter, .tracking_on_flag, .pd_select
	);

	ipc_link_model link (
		.mclk, .rst, .tx_valid, .tx_done, .rx_toggle, .rx_data, .rx_hardware_fault_flag
	);

	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Request pulse counters and hang guard
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		for (int i = 0; i < 8; i++)
		begin
			if (tx_irq[i] === 1'b1)
				tx_irqs[i]++;
			if (rx_irq[i] === 1'b1)
				rx_irqs[i]++;
		end
		if (cycles == 20000)
		begin
			n_errors++;
			end_sim();
		end
	end

	// ------------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask

	// Command word, then the first result word
	task automatic ask(input logic [15:0] c, output logic [31:0] d);
		wr(ipc_pkg::ADDR_CMD, {16'h0000, c});
		rd(ipc_pkg::ADDR_DATA, d);
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		rd(ipc_pkg::ADDR_CTRL, w);
		chk("ctrl reset", 32'h0, w);
		rd(ipc_pkg::ADDR_STAT, w);
		chk("stat reset", 32'h0, w);
		rd(4'h2, w);
		chk("unmapped", 32'h0, w);
		wr(ipc_pkg::ADDR_CTRL, 32'h00000003);
		// One character to every port, back to back
		for (int n = 0; n < 8; n++)
		begin
			ch = (n == 7) ? 8'hFF : 8'(n) * 8'h24;
			wr(ipc_pkg::ADDR_CMD, {16'h0000, 8'h18, 8'(n)});
			wr(ipc_pkg::ADDR_DATA, {24'h0, ch});
			#1;
			chk("tx_valid", 32'h1, {31'h0, tx_valid[n]});
			chk("tx_char", {24'h0, ch}, {24'h0, tx_char[n]});
		end
		ask(16'h1A01, w);
		chk("ps board2 busy", 32'h0, w & 32'h0000000F);
		repeat (80) @(posedge mclk);
		ask(16'h1A00, w);
		chk("ps board1 free", 32'h000F, w);
		ask(16'h1A01, w);
		chk("ps board2 free", 32'h000F, w);
		for (int n = 0; n < 8; n++)
			chk("tx_irq count", 32'h1, 32'(tx_irqs[n]));
		// Reuse a port only after it has finished
		wr(ipc_pkg::ADDR_CMD, 32'h00001800);
		wr(ipc_pkg::ADDR_DATA, 32'h0000005A);
		#1;
		chk("tx_char reuse", 32'h5A, {24'h0, tx_char[0]});
		repeat (40) @(posedge mclk);
		chk("tx_irq reuse", 32'h2, 32'(tx_irqs[0]));
		// Single byte, status bit, read and clear
		link.send(2, 8'hA5, 1'b0);
		chk("rx_irq count", 32'h1, 32'(rx_irqs[2]));
		ask(16'h1A00, w);
		chk("ps new data", 32'h004F, w);
		ask(16'h1902, w);
		chk("rx word", 32'h00A5, w);
		ask(16'h1A00, w);
		chk("ps cleared", 32'h000F, w);
		ask(16'h1902, w);
		chk("rx empty", 32'h2000, w);
		link.send(7, 8'h3C, 1'b1);
		ask(16'h1907, w);
		chk("rx fault", 32'h803C, w);
		// Fill one buffer past its depth, then drain it
		for (int i = 0; i < 17; i++)
			link.send(5, 8'(i), 1'b0);
		rd(ipc_pkg::ADDR_STAT, w);
		chk("stat rx nonempty", 32'h0000_2000, w);
		ask(16'h1905, w);
		chk("rx overrun", 32'h4000, w);
		for (int i = 1; i < 16; i++)
		begin
			ask(16'h1905, w);
			chk("rx fifo", 32'(i), w);
		end
		ask(16'h1905, w);
		chk("rx drained", 32'h2000, w);
		// Enter switch on a selected cursor
		@(posedge mclk);
		cur_x[1] <= 10'h155;
		cur_y[1] <= 10'h2AA;
		cur_x[2] <= 10'h0C3;
		cur_y[2] <= 10'h011;
		cursor_shown_flag <= 4'h2;
		repeat (10) @(posedge mclk);
		pd_select <= 2'h1;
		tracking_on_flag <= 1'b1;
		pd_enter <= 1'b1;
		repeat (10) @(posedge mclk);
		pd_enter <= 1'b0;
		repeat (10) @(posedge mclk);
		ask(16'h1A00, w);
		chk("ps enter event", 32'h020F, w);
		ask(16'h1701, w);
		chk("cursor1 x", 32'h0155, w);
		rd(ipc_pkg::ADDR_DATA, w);
		chk("cursor1 y", 32'h16AA, w);
		ask(16'h1A00, w);
		chk("ps event cleared", 32'h000F, w);
		// Tracked move of another cursor
		@(posedge mclk);
		pd_select <= 2'h2;
		repeat (10) @(posedge mclk);
		cur_x[2] <= 10'h0C4;
		cursor_flash_flag <= 4'h4;
		repeat (10) @(posedge mclk);
		ask(16'h1A01, w);
		chk("ps move event", 32'h010F, w);
		ask(16'h1702, w);
		chk("cursor2 x", 32'h00C4, w);
		rd(ipc_pkg::ADDR_DATA, w);
		chk("cursor2 y", 32'h1811, w);
		// Absent port, cursor and board
		ask(16'h1909, w);
		chk("absent port", 32'h2000, w);
		ask(16'h1704, w);
		chk("absent cursor", 32'h0, w);
		rd(ipc_pkg::ADDR_STAT, w);
		chk("stat one word left", 32'h0001_0000, w);
		ask(16'h1A02, w);
		chk("absent board", 32'h0, w);
		wr(ipc_pkg::ADDR_CMD, 32'h00001809);
		rd(ipc_pkg::ADDR_STAT, w);
		chk("stat wait char", 32'h0004_0000, w);
		wr(ipc_pkg::ADDR_DATA, 32'h00000077);
		#1;
		chk("absent write", 32'h0, {24'h0, tx_valid});
		// Reset in mid-run drops buffered bytes
		link.send(0, 8'h11, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		ask(16'h1900, w);
		chk("rx after reset", 32'h2000, w);
		rd(ipc_pkg::ADDR_CTRL, w);
		chk("ctrl after reset", 32'h0, w);
		rd(ipc_pkg::ADDR_STAT, w);
		chk("stat after reset", 32'h0, w);
		end_sim();
	end
endmodule
